// *** ccr_regs.sv ***
// Codec control registers and audio-core control with safeload engine.
// Assumes a plain register port synchronous to clk_sys; the memories,
// converters and clock logic sit outside and follow the outputs here.
`timescale 1ns/1ps

module ccr_regs (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic src_locked,
    input wire logic slew_mute_done,
    input wire logic data_init_done,
    output logic [3:0] analog_in_route,
    output logic [15:0] block_power,
    output logic hp_mute,
    output logic [4:0] hp_atten,
    output logic src_mux_en,
    output logic master_clock_out_en,
    output logic mclk_rate_1024x,
    output logic mclk_rate_128x,
    output logic [1:0] mult_clk_sel,
    output logic mult_in_use,
    output logic dac_chop_en,
    output logic hp_chop_en,
    output logic serial_out_two_three_en,
    output logic target_zero,
    output logic acc_hold_zero,
    output logic mult_force_zero,
    output logic input_zero,
    output logic data_init_req,
    output logic mem_wr,
    output logic mem_to_param,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_data
);
    // ========================================================
    // Decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic pair_hit(input logic [15:0] a, input logic [15:0] base,
                                      input int i);
        pair_hit = (a == base + 16'(i));
    endfunction : pair_hit

    localparam int NPAIR = ccr_pkg::NPAIR;
    localparam ccr_pkg::ccr_sl_e SL_IDLE = ccr_pkg::SL_IDLE;
    localparam ccr_pkg::ccr_sl_e SL_RUN = ccr_pkg::SL_RUN;

    logic [3:0] ain_q;
    logic [15:0] power_q;
    logic [7:0] hp_level_q;
    logic [8:0] clk_src_q;
    logic dac_chop_q;
    logic hp_chop_q;
    logic [15:0] core_q;
    logic [15:0] core_d;
    logic [15:0] rdata_q;
    logic [15:0] rd_val;
    logic [15:0] sl_addr_q [NPAIR];
    logic [15:0] sl_data_q [NPAIR];
    logic sl_written_q [NPAIR];
    ccr_pkg::ccr_sl_e sl_state_q;
    logic [2:0] sl_idx_q;
    logic sl_par_q;
    logic sl_done;
    logic mem_wr_q;
    logic mem_par_q;
    logic [15:0] mem_addr_q;
    logic [15:0] mem_data_q;
    localparam logic [15:0] CC_PLAIN_L = ccr_pkg::CC_PLAIN;
    localparam logic [15:0] CC_SELF_L = ccr_pkg::CC_SELF;

    // ========================================================
    // Plain control registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ain_q <= ccr_pkg::RST_AIN_SEL;
            power_q <= ccr_pkg::RST_POWER;
            hp_level_q <= 8'h00;
            clk_src_q <= 9'h000;
            dac_chop_q <= 1'b0;
            hp_chop_q <= 1'b0;
        end else if (reg_wr) begin
            // Reserved positions are simply not stored.
            if (hit(reg_addr, ccr_pkg::OFF_AIN_SEL)) begin
                ain_q <= reg_wdata[3:0];
            end
            if (hit(reg_addr, ccr_pkg::OFF_POWER)) begin
                power_q <= reg_wdata;
            end
            if (hit(reg_addr, ccr_pkg::OFF_HP_LEVEL)) begin
                hp_level_q <= {reg_wdata[7], 2'b00, reg_wdata[4:0]};
            end
            if (hit(reg_addr, ccr_pkg::OFF_CLK_SRC)) begin
                // Lock bit position is not stored; it always reads live.
                clk_src_q <= {reg_wdata[8], 1'b0, reg_wdata[6:0]};
            end
            if (hit(reg_addr, ccr_pkg::OFF_DAC_CHOP)) begin
                dac_chop_q <= reg_wdata[ccr_pkg::DAC_CHOP_BIT];
            end
            if (hit(reg_addr, ccr_pkg::OFF_HP_CHOP)) begin
                hp_chop_q <= reg_wdata[ccr_pkg::HP_CHOP_BIT];
            end
        end
    end

    // ========================================================
    // Audio core control
    // Writing 0 to a self-clearing bit cannot abort a running operation;
    // a completion and a new request in one cycle leave the bit set.
    always_comb begin
        core_d = core_q;
        if (data_init_done) begin
            core_d[ccr_pkg::CC_INIT] = 1'b0;
        end
        if (sl_done && !sl_par_q) begin
            core_d[ccr_pkg::CC_SL_TGT] = 1'b0;
        end
        if (sl_done && sl_par_q) begin
            core_d[ccr_pkg::CC_SL_PAR] = 1'b0;
        end
        if (reg_rd && hit(reg_addr, ccr_pkg::OFF_CORE)) begin
            core_d[ccr_pkg::CC_SLEW_DONE] = 1'b0;
        end
        if (slew_mute_done) begin
            core_d[ccr_pkg::CC_SLEW_DONE] = 1'b1;
        end
        if (reg_wr && hit(reg_addr, ccr_pkg::OFF_CORE)) begin
            core_d = (core_d & ~CC_PLAIN_L) | (reg_wdata & CC_PLAIN_L);
            core_d = core_d | (reg_wdata & CC_SELF_L);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_q <= ccr_pkg::RST_CORE;
        end else begin
            core_q <= core_d;
        end
    end

    // ========================================================
    // Safeload holding pairs
    generate
        for (genvar g = 0; g < NPAIR; g++) begin : g_pair
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    sl_addr_q[g] <= 16'h0000;
                    sl_data_q[g] <= 16'h0000;
                    sl_written_q[g] <= 1'b0;
                end else begin
                    if (reg_wr && pair_hit(reg_addr, ccr_pkg::OFF_SL_ADDR0, g)) begin
                        sl_addr_q[g] <= reg_wdata;
                    end
                    if (reg_wr && pair_hit(reg_addr, ccr_pkg::OFF_SL_DATA0, g)) begin
                        sl_data_q[g] <= reg_wdata;
                    end
                    // A fresh write in the cycle the pair is sent marks it again.
                    if (reg_wr && (pair_hit(reg_addr, ccr_pkg::OFF_SL_ADDR0, g) ||
                                   pair_hit(reg_addr, ccr_pkg::OFF_SL_DATA0, g))) begin
                        sl_written_q[g] <= 1'b1;
                    end else if (sl_state_q == SL_RUN && sl_idx_q == 3'(g)) begin
                        sl_written_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ========================================================
    // Safeload engine: one pair per cycle, target before parameter.
    assign sl_done = (sl_state_q == SL_RUN) && (sl_idx_q == ccr_pkg::LAST_PAIR);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sl_state_q <= SL_IDLE;
            sl_idx_q <= 3'h0;
            sl_par_q <= 1'b0;
        end else begin
            unique case (sl_state_q)
                SL_IDLE: begin
                    sl_idx_q <= 3'h0;
                    if (core_q[ccr_pkg::CC_SL_TGT]) begin
                        sl_state_q <= SL_RUN;
                        sl_par_q <= 1'b0;
                    end else if (core_q[ccr_pkg::CC_SL_PAR]) begin
                        sl_state_q <= SL_RUN;
                        sl_par_q <= 1'b1;
                    end
                end
                SL_RUN: begin
                    sl_idx_q <= sl_idx_q + 3'h1;
                    if (sl_done) begin
                        sl_state_q <= SL_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_wr_q <= 1'b0;
            mem_par_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_data_q <= 16'h0000;
        end else begin
            mem_wr_q <= 1'b0;
            if (sl_state_q == SL_RUN && sl_written_q[sl_idx_q]) begin
                // Address 0 names the first location; no offset is applied.
                mem_wr_q <= 1'b1;
                mem_par_q <= sl_par_q;
                mem_addr_q <= sl_addr_q[sl_idx_q];
                mem_data_q <= sl_data_q[sl_idx_q];
            end
        end
    end

    // ========================================================
    // Read port
    always_comb begin
        rd_val = 16'h0000;
        if (hit(reg_addr, ccr_pkg::OFF_AIN_SEL)) begin
            rd_val = {12'h000, ain_q};
        end else if (hit(reg_addr, ccr_pkg::OFF_POWER)) begin
            rd_val = power_q;
        end else if (hit(reg_addr, ccr_pkg::OFF_HP_LEVEL)) begin
            rd_val = {8'h00, hp_level_q};
        end else if (hit(reg_addr, ccr_pkg::OFF_CLK_SRC)) begin
            rd_val = {3'h0, ccr_pkg::CS_RSV_ONES, clk_src_q};
            rd_val[ccr_pkg::CS_LOCK] = src_locked;
        end else if (hit(reg_addr, ccr_pkg::OFF_CORE)) begin
            rd_val = core_q;
        end else if (hit(reg_addr, ccr_pkg::OFF_DAC_CHOP)) begin
            rd_val[ccr_pkg::DAC_CHOP_BIT] = dac_chop_q;
        end else if (hit(reg_addr, ccr_pkg::OFF_HP_CHOP)) begin
            rd_val[ccr_pkg::HP_CHOP_BIT] = hp_chop_q;
        end else begin
            for (int i = 0; i < NPAIR; i++) begin
                if (pair_hit(reg_addr, ccr_pkg::OFF_SL_ADDR0, i)) begin
                    rd_val = sl_addr_q[i];
                end
                if (pair_hit(reg_addr, ccr_pkg::OFF_SL_DATA0, i)) begin
                    rd_val = sl_data_q[i];
                end
            end
        end
    end

    // Read data stand only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_val : 16'h0000;
        end
    end

    // ========================================================
    // Outputs
    assign reg_rdata = rdata_q;
    assign analog_in_route = ain_q;
    assign block_power = power_q;
    assign hp_mute = hp_level_q[ccr_pkg::HP_MUTE_BIT];
    assign hp_atten = hp_level_q[ccr_pkg::HP_ATT_LSB +: 5];
    assign src_mux_en = clk_src_q[ccr_pkg::CS_SRC_MUX];
    assign master_clock_out_en = clk_src_q[ccr_pkg::CS_MCLK_EN];
    // Select codes 4 to 7 all drive the 128x output; codes 0, 2 and 3 leave both rate outputs off.
    assign mclk_rate_1024x = clk_src_q[ccr_pkg::CS_MCLK_LSB +: 3] == ccr_pkg::MCLK_1024;
    assign mclk_rate_128x = clk_src_q[ccr_pkg::CS_MCLK_LSB + 2];
    assign mult_clk_sel = clk_src_q[ccr_pkg::CS_MUL_LSB +: 2];
    assign mult_in_use = clk_src_q[ccr_pkg::CS_MUL_EN];
    assign dac_chop_en = !dac_chop_q;
    assign hp_chop_en = !hp_chop_q;
    assign serial_out_two_three_en = core_q[ccr_pkg::CC_SDO_EN];
    assign target_zero = core_q[ccr_pkg::CC_TGT_ZERO];
    assign acc_hold_zero = !core_q[ccr_pkg::CC_RUN];
    assign mult_force_zero = core_q[ccr_pkg::CC_MUL_ZERO];
    assign input_zero = core_q[ccr_pkg::CC_IN_ZERO];
    assign data_init_req = core_q[ccr_pkg::CC_INIT];
    assign mem_wr = mem_wr_q;
    assign mem_to_param = mem_par_q;
    assign mem_addr = mem_addr_q;
    assign mem_data = mem_data_q;

    // ========================================================
    // Assertions
    property p_ain_reset;
        @(posedge clk_sys) $rose(nrst) |-> analog_in_route == 4'h1;
    endproperty
    a_ain_reset: assert property (p_ain_reset) else $error("selector reset wrong");

    property p_power_wr;
        @(posedge clk_sys) disable iff (!nrst)
            reg_wr && reg_addr == ccr_pkg::OFF_POWER |=> block_power == $past(reg_wdata);
    endproperty
    a_power_wr: assert property (p_power_wr) else $error("power write lost");

    property p_rsv_ones;
        @(posedge clk_sys) disable iff (!nrst)
            reg_rd && reg_addr == ccr_pkg::OFF_CLK_SRC |=> reg_rdata[12:9] == 4'hF;
    endproperty
    a_rsv_ones: assert property (p_rsv_ones) else $error("reserved ones missing");

    property p_lock_read;
        @(posedge clk_sys) disable iff (!nrst)
            reg_rd && reg_addr == ccr_pkg::OFF_CLK_SRC |=> reg_rdata[7] == $past(src_locked);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock bit wrong");

    property p_hp_chop;
        @(posedge clk_sys) disable iff (!nrst)
            reg_wr && reg_addr == ccr_pkg::OFF_HP_CHOP |=> hp_chop_en == !$past(reg_wdata[0]);
    endproperty
    a_hp_chop: assert property (p_hp_chop) else $error("chop sense wrong");

    property p_sdo_reset;
        @(posedge clk_sys) $rose(nrst) |-> serial_out_two_three_en && acc_hold_zero;
    endproperty
    a_sdo_reset: assert property (p_sdo_reset) else $error("core reset wrong");

    property p_slew_clear;
        @(posedge clk_sys) disable iff (!nrst)
            reg_rd && reg_addr == ccr_pkg::OFF_CORE && !slew_mute_done |=> !core_q[13];
    endproperty
    a_slew_clear: assert property (p_slew_clear) else $error("slew flag kept");

    property p_init_done;
        @(posedge clk_sys) disable iff (!nrst)
            data_init_done && !(reg_wr && reg_addr == ccr_pkg::OFF_CORE) |=> !data_init_req;
    endproperty
    a_init_done: assert property (p_init_done) else $error("init not cleared");

    property p_sl_tgt_ends;
        @(posedge clk_sys) disable iff (!nrst)
            $rose(core_q[5]) && sl_state_q == SL_IDLE |-> ##[5:6] !core_q[5];
    endproperty
    a_sl_tgt_ends: assert property (p_sl_tgt_ends) else $error("target load stuck");

    property p_sl_only_written;
        @(posedge clk_sys) disable iff (!nrst)
            sl_state_q == SL_RUN && !sl_written_q[sl_idx_q] |=> !mem_wr;
    endproperty
    a_sl_only_written: assert property (p_sl_only_written)
        else $error("unwritten pair sent");

    c_sl_tgt: cover property (@(posedge clk_sys) disable iff (!nrst) mem_wr && !mem_to_param);
    c_sl_par: cover property (@(posedge clk_sys) disable iff (!nrst) mem_wr && mem_to_param);
    c_slew: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(core_q[13]));
    c_init: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(data_init_req));
endmodule : ccr_regs

// *** ccr_pkg.sv ***
// Constants for the codec control and audio-core register bank.
// Assumes a 16-bit register port and a single 200 MHz core clock.
package ccr_pkg;
    // ========================================================
    // Register offsets
    localparam logic [15:0] OFF_AIN_SEL = 16'h1057;
    localparam logic [15:0] OFF_POWER = 16'h1058;
    localparam logic [15:0] OFF_CLK_SRC = 16'h1059;
    localparam logic [15:0] OFF_HP_LEVEL = 16'h105A;
    localparam logic [15:0] OFF_CORE = 16'h1060;
    localparam logic [15:0] OFF_DAC_CHOP = 16'h110D;
    localparam logic [15:0] OFF_HP_CHOP = 16'h1113;
    localparam logic [15:0] OFF_SL_ADDR0 = 16'h1070;
    localparam logic [15:0] OFF_SL_DATA0 = 16'h1078;

    // ========================================================
    // Reset values
    localparam logic [3:0] RST_AIN_SEL = 4'h1;
    localparam logic [15:0] RST_POWER = 16'h0000;
    localparam logic [15:0] RST_CORE = 16'h4000;

    // ========================================================
    // Field positions
    localparam int HP_MUTE_BIT = 7;
    localparam int HP_ATT_LSB = 0;
    localparam int CS_RSV_LSB = 9;
    localparam logic [3:0] CS_RSV_ONES = 4'hF;
    localparam int CS_SRC_MUX = 8;
    localparam int CS_LOCK = 7;
    localparam int CS_MCLK_EN = 6;
    localparam int CS_MCLK_LSB = 3;
    localparam logic [2:0] MCLK_1024 = 3'h1;
    localparam int CS_MUL_LSB = 1;
    localparam int CS_MUL_EN = 0;
    localparam int DAC_CHOP_BIT = 4;
    localparam int HP_CHOP_BIT = 0;
    localparam int CC_SDO_EN = 14;
    localparam int CC_SLEW_DONE = 13;
    localparam int CC_TGT_ZERO = 12;
    localparam int CC_RUN = 9;
    localparam int CC_MUL_ZERO = 8;
    localparam int CC_INIT = 7;
    localparam int CC_IN_ZERO = 6;
    localparam int CC_SL_TGT = 5;
    localparam int CC_SL_PAR = 4;
    // Bits stored as written; self-clearing and read-only bits excluded.
    localparam logic [15:0] CC_PLAIN = 16'h5340;
    localparam logic [15:0] CC_SELF = 16'h00B0;

    // ========================================================
    // Safeload holding pairs
    localparam int NPAIR = 5;
    localparam logic [2:0] LAST_PAIR = 3'h4;

    typedef enum logic [0:0] {
        SL_IDLE = 1'b0,
        SL_RUN = 1'b1
    } ccr_sl_e;
endpackage : ccr_pkg

// *** tb_codec_control_and_core_regs.sv ***
// Self-checking testbench for the codec control and audio-core register bank.
// Assumes ccr_regs and ccr_pkg are compiled first; the bench is the only bus master.
`timescale 1ns/1ps

module tb_codec_control_and_core_regs;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic src_locked = 1'b0;
    logic slew_mute_done = 1'b0;
    logic data_init_done = 1'b0;
    logic [3:0] analog_in_route;
    logic [15:0] block_power;
    logic hp_mute, src_mux_en, master_clock_out_en, mclk_rate_1024x, mclk_rate_128x;
    logic [4:0] hp_atten;
    logic [1:0] mult_clk_sel;
    logic mult_in_use, dac_chop_en, hp_chop_en, serial_out_two_three_en, target_zero;
    logic acc_hold_zero, mult_force_zero, input_zero, data_init_req, mem_wr, mem_to_param;
    logic [15:0] mem_addr, mem_data, v;
    int miscompares = 0;
    int n_tests = 0;

    ccr_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_locked(src_locked), .slew_mute_done(slew_mute_done),
        .data_init_done(data_init_done), .analog_in_route(analog_in_route),
        .block_power(block_power), .hp_mute(hp_mute), .hp_atten(hp_atten),
        .src_mux_en(src_mux_en), .master_clock_out_en(master_clock_out_en),
        .mclk_rate_1024x(mclk_rate_1024x), .mclk_rate_128x(mclk_rate_128x),
        .mult_clk_sel(mult_clk_sel), .mult_in_use(mult_in_use), .dac_chop_en(dac_chop_en),
        .hp_chop_en(hp_chop_en), .serial_out_two_three_en(serial_out_two_three_en),
        .target_zero(target_zero), .acc_hold_zero(acc_hold_zero),
        .mult_force_zero(mult_force_zero), .input_zero(input_zero),
        .data_init_req(data_init_req), .mem_wr(mem_wr), .mem_to_param(mem_to_param),
        .mem_addr(mem_addr), .mem_data(mem_data));

    // ========================================================
    // Clock, watchdog and bus tasks
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        miscompares++;
        final_report();
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic pulse_in(input int which);
        @(posedge clk_sys);
        if (which == 0) slew_mute_done <= 1'b1;
        else data_init_done <= 1'b1;
        @(posedge clk_sys);
        slew_mute_done <= 1'b0;
        data_init_done <= 1'b0;
        #1;
    endtask : pulse_in

    // ========================================================
    // Scenarios
    task automatic t_reset;
        chk({15'h0, dac_chop_en & hp_chop_en & acc_hold_zero}, 16'h0001);
        rd(ccr_pkg::OFF_AIN_SEL, v); chk(v, 16'h0001);
        rd(ccr_pkg::OFF_POWER, v); chk(v, 16'h0000);
        rd(ccr_pkg::OFF_HP_CHOP, v); chk(v, 16'h0000);
        rd(ccr_pkg::OFF_CORE, v); chk(v, 16'h4000);
        chk({15'h0, serial_out_two_three_en}, 16'h0001);
        rd(16'h1234, v); chk(v, 16'h0000);
    endtask : t_reset

    task automatic t_user_regs;
        wr(ccr_pkg::OFF_AIN_SEL, 16'hFFFA); chk({12'h0, analog_in_route}, 16'h000A);
        rd(ccr_pkg::OFF_AIN_SEL, v); chk(v, 16'h000A);
        wr(ccr_pkg::OFF_POWER, 16'h8001); chk(block_power, 16'h8001);
        wr(ccr_pkg::OFF_HP_LEVEL, 16'hFFFF); rd(ccr_pkg::OFF_HP_LEVEL, v);
        chk(v, 16'h009F);
        chk({10'h0, hp_mute, hp_atten}, 16'h003F);
        @(posedge clk_sys);
        src_locked <= 1'b1;
        wr(ccr_pkg::OFF_CLK_SRC, 16'h0000); rd(ccr_pkg::OFF_CLK_SRC, v);
        chk(v, 16'h1E80);
        @(posedge clk_sys);
        src_locked <= 1'b0;
        wr(ccr_pkg::OFF_CLK_SRC, 16'hFF45); rd(ccr_pkg::OFF_CLK_SRC, v);
        chk(v, 16'h1F45);
        chk({11'h0, src_mux_en, master_clock_out_en, mult_clk_sel, mult_in_use},
            16'h001D);
        for (int c = 0; c < 8; c++) begin
            wr(ccr_pkg::OFF_CLK_SRC, 16'(c << 3) | 16'h0006);
            chk({14'h0, mclk_rate_1024x, mclk_rate_128x},
                {14'h0, c == 1, c >= 4});
            chk({13'h0, master_clock_out_en, mult_clk_sel}, 16'h0003);
        end
        wr(ccr_pkg::OFF_DAC_CHOP, 16'h0010); chk({15'h0, dac_chop_en}, 16'h0000);
        wr(ccr_pkg::OFF_HP_CHOP, 16'h0001); chk({15'h0, hp_chop_en}, 16'h0000);
    endtask : t_user_regs

    task automatic t_core_bits;
        wr(ccr_pkg::OFF_CORE, 16'h1340);
        chk({11'h0, serial_out_two_three_en, target_zero, acc_hold_zero, mult_force_zero,
            input_zero}, 16'h000B);
        rd(ccr_pkg::OFF_CORE, v); chk(v, 16'h1340);
        pulse_in(0);
        rd(ccr_pkg::OFF_CORE, v); chk(v, 16'h3340);
        rd(ccr_pkg::OFF_CORE, v); chk(v, 16'h1340);
        wr(ccr_pkg::OFF_CORE, 16'h4280); chk({15'h0, data_init_req}, 16'h0001);
        pulse_in(1);
        rd(ccr_pkg::OFF_CORE, v); chk(v, 16'h4200);
    endtask : t_core_bits

    // Runs one transfer and checks the pulses against up to two expected pairs,
    // the first pair in the low half of ea and ed.
    task automatic sl_run(input logic [15:0] cmd, input int ne, input logic [31:0] ea,
                          input logic [31:0] ed);
        int n;
        n = 0;
        wr(ccr_pkg::OFF_CORE, cmd);
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            if (mem_wr === 1'b1) begin
                if (n < ne) begin
                    chk(mem_addr, ea[n*16 +: 16]);
                    chk(mem_data, ed[n*16 +: 16]);
                end
                chk({15'h0, mem_to_param}, {15'h0, cmd[4]});
                n++;
            end
        end
        chk(16'(n), 16'(ne));
        rd(ccr_pkg::OFF_CORE, v); chk(v, 16'h4200);
    endtask : sl_run

    task automatic t_safeload;
        wr(ccr_pkg::OFF_SL_ADDR0 + 16'h0001, 16'h0011);
        wr(ccr_pkg::OFF_SL_DATA0 + 16'h0001, 16'hA1A1);
        wr(ccr_pkg::OFF_SL_DATA0 + 16'h0004, 16'hA4A4);
        sl_run(16'h4220, 2, {16'h0000, 16'h0011}, {16'hA4A4, 16'hA1A1});
        wr(ccr_pkg::OFF_SL_DATA0, 16'hB0B0);
        sl_run(16'h4210, 1, {16'h0000, 16'h0000}, {16'h0000, 16'hB0B0});
    endtask : t_safeload

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_user_regs();
        t_core_bits();
        t_safeload();
        final_report();
    end
endmodule : tb_codec_control_and_core_regs
